// ==== src/gpch_params.svh ====
// Constants of the global parameter command handler.
// Assumes a byte stream of command frames and an external
// non-volatile memory answering with a one-cycle acknowledge.
// Contract
// - Instruction 9 writes the value into parameter type of bank 0, 2 or 3
// - Storage is banked: 0 settings, 2 user variables, 3 interrupt setup
// - A set to a bank 0 setting is copied to non-volatile memory
// - Instruction 10 replies status 100 with the addressed parameter value
// - Instruction 10 also loads the addressed value into the accumulator
// - Instruction 11, bank 2, stores the user variable, replies status 100
// - Instruction 12, bank 2, reloads the user variable from its stored copy
// - After power-up all user variables load before commands are accepted
// - Frame: address, instruction, type, bank, value MSB first, checksum
// - Parameter 66 of bank 0 holds the serial address, readable and writable
`ifndef GPCH_PARAMS_SVH
`define GPCH_PARAMS_SVH

`define GPCH_INS_SET      8'h09
`define GPCH_INS_GET      8'h0a
`define GPCH_INS_STORE    8'h0b
`define GPCH_INS_RESTORE  8'h0c

`define GPCH_BANK_SET     8'h00
`define GPCH_BANK_USER    8'h02
`define GPCH_BANK_IRQ     8'h03

`define GPCH_STAT_OK      8'h64
`define GPCH_STAT_BADSUM  8'h01
`define GPCH_STAT_BADCMD  8'h02
`define GPCH_STAT_BADTYPE 8'h03
`define GPCH_STAT_BADVAL  8'h04

`define GPCH_SERADDR_IDX  8'h42
`define GPCH_SERADDR_RST  32'h00000001

// Frame byte positions
`define GPCH_POS_ADDR     4'h0
`define GPCH_POS_INS      4'h1
`define GPCH_POS_TYPE     4'h2
`define GPCH_POS_BANK     4'h3
`define GPCH_POS_SUM      4'h8

`endif

// ==== src/gpch_pkg.sv ====
// Types of the global parameter command handler.
// Assumes nothing beyond a SystemVerilog compiler.
package gpch_pkg;

   typedef enum logic [2:0] {
      GPCH_S_INIT  = 3'b000,
      GPCH_S_RX    = 3'b001,
      GPCH_S_EXEC  = 3'b010,
      GPCH_S_NVWR  = 3'b011,
      GPCH_S_NVRD  = 3'b100,
      GPCH_S_REPLY = 3'b101
   } gpch_state_t;

   // Storage slot of a bank: 0 settings, 1 user, 2 interrupt
   typedef logic [1:0] gpch_slot_t;

endpackage

// ==== src/gpch_handler.sv ====
// Global parameter command handler: frame intake, decode, banked
// parameter storage, non-volatile store/restore and reply.
// Assumes frames arrive as bytes with valid/ready, and that the
// non-volatile memory answers each held request with one acknowledge pulse.
`timescale 1ns/1ps
`include "gpch_params.svh"

module gpch_handler #(
   parameter int NUM_PARAMS = 256
) (
   // Clock, reset, enable
   input  wire logic        MCLK_I,
   input  wire logic        RESETN_I,
   input  wire logic        CE_I,
   // Command byte stream
   input  wire logic        RX_VALID_I,
   input  wire logic [7:0]  RX_BYTE_I,
   output logic             RX_READY_O,
   // Reply
   output logic             REPLY_VALID_O,
   input  wire logic        REPLY_READY_I,
   output logic [7:0]       REPLY_INSTR_O,
   output logic [7:0]       REPLY_STATUS_O,
   output logic [31:0]      REPLY_VALUE_O,
   // Non-volatile memory
   output logic             NV_REQ_O,
   output logic             NV_WE_O,
   output logic [7:0]       NV_BANK_O,
   output logic [7:0]       NV_INDEX_O,
   output logic [31:0]      NV_WDATA_O,
   input  wire logic        NV_ACK_I,
   input  wire logic [31:0] NV_RDATA_I,
   // Status
   output logic [31:0]      ACCUM_O,
   output logic [7:0]       SER_ADDR_O,
   output logic             INIT_DONE_O
);

   localparam logic [7:0] LAST_IDX = 8'(NUM_PARAMS - 1);

   gpch_pkg::gpch_state_t state_ff;
   gpch_pkg::gpch_state_t nxt_state;

   logic [7:0]             frame_ff [0:8];
   logic [3:0]             rx_cnt_ff;
   logic [7:0]             sum_ff;
   logic [31:0]            gp_ff [0:2][0:255];
   logic [7:0]             status_ff;
   logic [7:0]             nxt_status;
   logic [31:0]            value_ff;
   logic [31:0]            nxt_value;
   logic [31:0]            accum_ff;
   logic                   nv_we_ff;
   logic [7:0]             nv_bank_ff;
   logic [7:0]             nv_idx_ff;
   logic [31:0]            nv_wdata_ff;

   logic                   accept;
   logic [7:0]             ins;
   logic [7:0]             typ;
   logic [7:0]             bank;
   logic [31:0]            val;
   logic                   sum_ok;
   logic                   addr_ok;
   logic                   bank_ok;
   logic                   type_ok;
   gpch_pkg::gpch_slot_t   slot;
   logic [31:0]            rd_val;
   logic                   wr_en;
   gpch_pkg::gpch_slot_t   wr_slot;
   logic [7:0]             wr_idx;
   logic [31:0]            wr_data;
   logic                   ld_acc;
   logic                   ld_nv;
   logic                   nv_we;

   // Frame fields, value most significant byte first
   assign ins     = frame_ff[`GPCH_POS_INS];
   assign typ     = frame_ff[`GPCH_POS_TYPE];
   assign bank    = frame_ff[`GPCH_POS_BANK];
   assign val     = {frame_ff[4], frame_ff[5], frame_ff[6], frame_ff[7]};
   assign sum_ok  = (sum_ff == frame_ff[`GPCH_POS_SUM]);
   assign addr_ok = (frame_ff[`GPCH_POS_ADDR] == SER_ADDR_O);
   assign type_ok = (typ <= LAST_IDX);
   assign bank_ok = (bank == `GPCH_BANK_SET) ||
                    (bank == `GPCH_BANK_USER) ||
                    (bank == `GPCH_BANK_IRQ);
   assign slot    = (bank == `GPCH_BANK_SET)  ? 2'h0 :
                    (bank == `GPCH_BANK_USER) ? 2'h1 : 2'h2;
   assign rd_val  = gp_ff[slot][typ];

   assign accept         = CE_I && RX_VALID_I && RX_READY_O;
   assign RX_READY_O     = (state_ff == gpch_pkg::GPCH_S_RX);
   assign REPLY_VALID_O  = (state_ff == gpch_pkg::GPCH_S_REPLY);
   assign NV_REQ_O       = (state_ff == gpch_pkg::GPCH_S_INIT) ||
                           (state_ff == gpch_pkg::GPCH_S_NVWR) ||
                           (state_ff == gpch_pkg::GPCH_S_NVRD);
   assign INIT_DONE_O    = (state_ff != gpch_pkg::GPCH_S_INIT);
   assign REPLY_INSTR_O  = ins;
   assign REPLY_STATUS_O = status_ff;
   assign REPLY_VALUE_O  = value_ff;
   assign ACCUM_O        = accum_ff;
   assign SER_ADDR_O     = gp_ff[0][`GPCH_SERADDR_IDX][7:0];
   assign NV_WE_O        = nv_we_ff;
   assign NV_BANK_O      = nv_bank_ff;
   assign NV_INDEX_O     = nv_idx_ff;
   assign NV_WDATA_O     = nv_wdata_ff;

   always_comb begin
      nxt_state  = state_ff;
      nxt_status = status_ff;
      nxt_value  = value_ff;
      wr_en      = 1'b0;
      wr_slot    = slot;
      wr_idx     = typ;
      wr_data    = val;
      ld_acc     = 1'b0;
      ld_nv      = 1'b0;
      nv_we      = 1'b0;
      case (state_ff)
         gpch_pkg::GPCH_S_INIT: begin
            if (NV_ACK_I) begin
               wr_en   = 1'b1;
               wr_slot = 2'h1;
               wr_idx  = nv_idx_ff;
               wr_data = NV_RDATA_I;
               if (nv_idx_ff == LAST_IDX) begin
                  nxt_state = gpch_pkg::GPCH_S_RX;
               end
            end
         end
         gpch_pkg::GPCH_S_RX: begin
            if (accept && rx_cnt_ff == `GPCH_POS_SUM) begin
               nxt_state = gpch_pkg::GPCH_S_EXEC;
            end
         end
         gpch_pkg::GPCH_S_EXEC: begin
            nxt_state  = gpch_pkg::GPCH_S_REPLY;
            nxt_status = `GPCH_STAT_OK;
            nxt_value  = 32'h0;
            if (!sum_ok) begin
               nxt_status = `GPCH_STAT_BADSUM;
            end else if (!addr_ok) begin
               // Frames for other nodes with a good checksum get no reply
               nxt_state = gpch_pkg::GPCH_S_RX;
            end else begin
               case (ins)
                  `GPCH_INS_SET: begin
                     if (!bank_ok) begin
                        nxt_status = `GPCH_STAT_BADVAL;
                     end else if (!type_ok) begin
                        nxt_status = `GPCH_STAT_BADTYPE;
                     end else begin
                        wr_en = 1'b1;
                        if (bank == `GPCH_BANK_SET) begin
                           ld_nv     = 1'b1;
                           nv_we     = 1'b1;
                           nxt_state = gpch_pkg::GPCH_S_NVWR;
                        end
                     end
                  end
                  `GPCH_INS_GET: begin
                     if (!bank_ok) begin
                        nxt_status = `GPCH_STAT_BADVAL;
                     end else if (!type_ok) begin
                        nxt_status = `GPCH_STAT_BADTYPE;
                     end else begin
                        nxt_value = rd_val;
                        ld_acc    = 1'b1;
                     end
                  end
                  `GPCH_INS_STORE: begin
                     if (bank != `GPCH_BANK_USER) begin
                        nxt_status = `GPCH_STAT_BADVAL;
                     end else if (!type_ok) begin
                        nxt_status = `GPCH_STAT_BADTYPE;
                     end else begin
                        ld_nv     = 1'b1;
                        nv_we     = 1'b1;
                        nxt_state = gpch_pkg::GPCH_S_NVWR;
                     end
                  end
                  `GPCH_INS_RESTORE: begin
                     if (bank != `GPCH_BANK_USER) begin
                        nxt_status = `GPCH_STAT_BADVAL;
                     end else if (!type_ok) begin
                        nxt_status = `GPCH_STAT_BADTYPE;
                     end else begin
                        ld_nv     = 1'b1;
                        nxt_state = gpch_pkg::GPCH_S_NVRD;
                     end
                  end
                  default: begin
                     nxt_status = `GPCH_STAT_BADCMD;
                  end
               endcase
            end
         end
         gpch_pkg::GPCH_S_NVWR: begin
            if (NV_ACK_I) begin
               nxt_state = gpch_pkg::GPCH_S_REPLY;
            end
         end
         gpch_pkg::GPCH_S_NVRD: begin
            if (NV_ACK_I) begin
               wr_en     = 1'b1;
               wr_slot   = 2'h1;
               wr_data   = NV_RDATA_I;
               nxt_state = gpch_pkg::GPCH_S_REPLY;
            end
         end
         gpch_pkg::GPCH_S_REPLY: begin
            if (REPLY_READY_I) begin
               nxt_state = gpch_pkg::GPCH_S_RX;
            end
         end
         default: begin
            nxt_state = gpch_pkg::GPCH_S_RX;
         end
      endcase
   end

   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         state_ff <= gpch_pkg::GPCH_S_INIT;
      end else if (CE_I) begin
         state_ff <= nxt_state;
      end
   end

   // Frame intake with running checksum over the first eight bytes
   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         rx_cnt_ff <= 4'h0;
         sum_ff    <= 8'h0;
         for (int i = 0; i < 9; i++) begin
            frame_ff[i] <= 8'h0;
         end
      end else if (accept) begin
         frame_ff[rx_cnt_ff] <= RX_BYTE_I;
         if (rx_cnt_ff == `GPCH_POS_SUM) begin
            rx_cnt_ff <= 4'h0;
         end else begin
            rx_cnt_ff <= rx_cnt_ff + 4'h1;
            sum_ff    <= (rx_cnt_ff == 4'h0) ? RX_BYTE_I
                                             : sum_ff + RX_BYTE_I;
         end
      end
   end

   // Reset fills the store so reads of unwritten parameters are defined
   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         for (int b = 0; b < 3; b++) begin
            for (int i = 0; i < 256; i++) begin
               gp_ff[b][i] <= 32'h0;
            end
         end
         gp_ff[0][`GPCH_SERADDR_IDX] <= `GPCH_SERADDR_RST;
      end else if (CE_I && wr_en) begin
         gp_ff[wr_slot][wr_idx] <= wr_data;
      end
   end

   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         status_ff <= `GPCH_STAT_OK;
         value_ff  <= 32'h0;
      end else if (CE_I) begin
         status_ff <= nxt_status;
         value_ff  <= nxt_value;
      end
   end

   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         accum_ff <= 32'h0;
      end else if (CE_I && ld_acc) begin
         accum_ff <= rd_val;
      end
   end

   // Index doubles as the power-up restore counter
   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         nv_we_ff    <= 1'b0;
         nv_bank_ff  <= `GPCH_BANK_USER;
         nv_idx_ff   <= 8'h0;
         nv_wdata_ff <= 32'h0;
      end else if (CE_I) begin
         if (state_ff == gpch_pkg::GPCH_S_INIT && NV_ACK_I) begin
            nv_idx_ff <= nv_idx_ff + 8'h1;
         end else if (ld_nv) begin
            nv_we_ff    <= nv_we;
            nv_bank_ff  <= bank;
            nv_idx_ff   <= typ;
            nv_wdata_ff <= (bank == `GPCH_BANK_SET) ? val : rd_val;
         end
      end
   end

   logic exec_go;
   assign exec_go = CE_I && state_ff == gpch_pkg::GPCH_S_EXEC &&
                    sum_ok && addr_ok && type_ok;

   chk_set_user: assert property (
      @(posedge MCLK_I) disable iff (!RESETN_I)
      exec_go && ins == `GPCH_INS_SET && bank == `GPCH_BANK_USER
      |=> REPLY_VALID_O && REPLY_STATUS_O == 8'h64 &&
          gp_ff[1][typ] == val)
      else $error("set of user variable not applied");

   chk_bank_reject: assert property (
      @(posedge MCLK_I) disable iff (!RESETN_I)
      exec_go && ins == `GPCH_INS_SET && bank == 8'h01
      |=> REPLY_STATUS_O == 8'h04 && !NV_REQ_O)
      else $error("bank 1 accepted");

   chk_set_persist: assert property (
      @(posedge MCLK_I) disable iff (!RESETN_I)
      exec_go && ins == `GPCH_INS_SET && bank == `GPCH_BANK_SET
      |=> NV_REQ_O && NV_WE_O && NV_WDATA_O == $past(val) &&
          NV_INDEX_O == $past(typ))
      else $error("bank 0 set not written to memory");

   chk_get_reply: assert property (
      @(posedge MCLK_I) disable iff (!RESETN_I)
      exec_go && ins == `GPCH_INS_GET && bank_ok
      |=> REPLY_VALID_O && REPLY_STATUS_O == 8'h64 &&
          REPLY_VALUE_O == $past(rd_val))
      else $error("get reply wrong");

   chk_get_accum: assert property (
      @(posedge MCLK_I) disable iff (!RESETN_I)
      exec_go && ins == `GPCH_INS_GET && bank_ok
      |=> ACCUM_O == REPLY_VALUE_O)
      else $error("accumulator not loaded");

   chk_store_user: assert property (
      @(posedge MCLK_I) disable iff (!RESETN_I)
      exec_go && ins == `GPCH_INS_STORE && bank == `GPCH_BANK_USER
      |=> NV_REQ_O && NV_WE_O && NV_WDATA_O == $past(rd_val))
      else $error("store did not write memory");

   chk_restore_user: assert property (
      @(posedge MCLK_I) disable iff (!RESETN_I)
      CE_I && state_ff == gpch_pkg::GPCH_S_NVRD && NV_ACK_I
      |=> gp_ff[1][typ] == $past(NV_RDATA_I) && REPLY_VALID_O)
      else $error("restore did not load variable");

   chk_init_gate: assert property (
      @(posedge MCLK_I) disable iff (!RESETN_I)
      CE_I && state_ff == gpch_pkg::GPCH_S_INIT && NV_ACK_I &&
      nv_idx_ff != LAST_IDX
      |=> !RX_READY_O && NV_REQ_O && !NV_WE_O)
      else $error("commands accepted during restore");

   chk_frame_len: assert property (
      @(posedge MCLK_I) disable iff (!RESETN_I)
      accept && rx_cnt_ff == 4'h8
      |=> state_ff == gpch_pkg::GPCH_S_EXEC && !RX_READY_O)
      else $error("frame not nine bytes");

   chk_ser_addr: assert property (
      @(posedge MCLK_I) disable iff (!RESETN_I)
      exec_go && ins == `GPCH_INS_SET && bank == `GPCH_BANK_SET &&
      typ == 8'h42
      |=> SER_ADDR_O == $past(val[7:0]))
      else $error("serial address not updated");

   chk_bad_sum: assert property (
      @(posedge MCLK_I) disable iff (!RESETN_I)
      CE_I && state_ff == gpch_pkg::GPCH_S_EXEC && !sum_ok
      |=> REPLY_VALID_O && REPLY_STATUS_O == 8'h01 && !$changed(ACCUM_O))
      else $error("bad checksum executed");

endmodule

// ==== tb/gpch_nv_model.sv ====
// Behavioural non-volatile memory that stands beside the command handler.
// Assumes the handler holds a request until it samples one ack pulse.
`timescale 1ns/1ps

module gpch_nv_model #(
   parameter logic [31:0] PRELOAD = 32'ha5000000
) (
   // Clock and reset
   input  wire logic        mclk_i,
   input  wire logic        resetn_i,
   // Response speed
   input  wire logic        slow_i,
   // Memory port
   input  wire logic        req_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  bank_i,
   input  wire logic [7:0]  index_i,
   input  wire logic [31:0] wdata_i,
   output logic             ack_o,
   output logic [31:0]      rdata_o
);
   logic [31:0] mem [0:1023];
   logic [3:0]  wait_ff;
   logic [31:0] last_ff;

   // Each word starts with a pattern built from its own bank and index
   initial begin
      for (int i = 0; i < 1024; i++) begin
         mem[i] = PRELOAD | 32'(i);
      end
   end

   // A gap cycle after each ack lets the handler move to its next request
   always @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ack_o   <= 1'b0;
         wait_ff <= 4'h0;
         last_ff <= 32'h0;
      end else if (ack_o || !req_i) begin
         ack_o   <= 1'b0;
         wait_ff <= 4'h0;
      end else if (wait_ff >= (slow_i ? 4'h4 : 4'h0)) begin
         ack_o <= 1'b1;
         if (we_i) begin
            mem[{bank_i[1:0], index_i}] <= wdata_i;
         end else begin
            last_ff <= mem[{bank_i[1:0], index_i}];
         end
      end else begin
         wait_ff <= wait_ff + 4'h1;
      end
   end

   // Read data is only meaningful with the ack; otherwise it is scrambled
   assign rdata_o = ack_o ? last_ff : ~last_ff;
endmodule

// ==== tb/gpch_handler_tb_top.sv ====
// Self-checking bench of the global parameter command handler.
// Assumes the memory model in gpch_nv_model.sv and the handler's header.
`timescale 1ns/1ps
`include "gpch_params.svh"

module gpch_handler_tb_top;
   localparam int          NPAR    = 128;
   localparam logic [31:0] PRELOAD = 32'ha5000000;
   logic        mclk, resetn, rx_valid, reply_ready, slow, ce;
   logic [7:0]  rx_byte, reply_instr, reply_status, nv_bank, nv_index;
   logic [7:0]  ser_addr, dev_addr;
   logic        rx_ready, reply_valid, nv_req, nv_we, nv_ack, init_done;
   logic [31:0] reply_value, nv_wdata, nv_rdata, accum;
   int          n_errors, num_checks;

   gpch_handler #(.NUM_PARAMS(NPAR)) i_gpch_handler (
      .MCLK_I(mclk), .RESETN_I(resetn), .CE_I(ce),
      .RX_VALID_I(rx_valid), .RX_BYTE_I(rx_byte), .RX_READY_O(rx_ready),
      .REPLY_VALID_O(reply_valid), .REPLY_READY_I(reply_ready),
      .REPLY_INSTR_O(reply_instr), .REPLY_STATUS_O(reply_status),
      .REPLY_VALUE_O(reply_value), .NV_REQ_O(nv_req), .NV_WE_O(nv_we),
      .NV_BANK_O(nv_bank), .NV_INDEX_O(nv_index), .NV_WDATA_O(nv_wdata),
      .NV_ACK_I(nv_ack), .NV_RDATA_I(nv_rdata), .ACCUM_O(accum),
      .SER_ADDR_O(ser_addr), .INIT_DONE_O(init_done));

   gpch_nv_model #(.PRELOAD(PRELOAD)) i_gpch_nv_model (
      .mclk_i(mclk), .resetn_i(resetn), .slow_i(slow), .req_i(nv_req),
      .we_i(nv_we), .bank_i(nv_bank), .index_i(nv_index),
      .wdata_i(nv_wdata), .ack_o(nv_ack), .rdata_o(nv_rdata));

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   function automatic logic [31:0] nv_init(input logic [1:0] b,
                                           input logic [7:0] i);
      return PRELOAD | {22'h0, b, i};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("Checks %0d, errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic send_frame(input logic [7:0] ins, input logic [7:0] typ,
         input logic [7:0] bank, input logic [31:0] val, input logic bad);
      logic [7:0] b [0:8];
      int n;
      b = '{dev_addr, ins, typ, bank, val[31:24], val[23:16], val[15:8],
            val[7:0], 8'h00};
      for (int i = 0; i < 8; i++) b[8] = b[8] + b[i];
      b[8] = b[8] + {7'h0, bad};
      for (int i = 0; i < 9; i++) begin
         rx_valid <= 1'b1;
         rx_byte  <= b[i];
         n = 0;
         @(negedge mclk);
         while (rx_ready !== 1'b1 && n < 2000) begin
            @(negedge mclk);
            n++;
         end
         if (n >= 2000) n_errors++;
         @(posedge mclk);
      end
      rx_valid <= 1'b0;
   endtask

   // Sends one frame, waits for the reply, judges it and accepts it
   task automatic cmd(input logic [7:0] ins, input logic [7:0] typ,
         input logic [7:0] bank, input logic [31:0] val, input logic bad,
         input logic [7:0] exp_st, input logic [31:0] exp_val);
      int n;
      send_frame(ins, typ, bank, val, bad);
      n = 0;
      @(negedge mclk);
      while (reply_valid !== 1'b1 && n < 2000) begin
         @(negedge mclk);
         n++;
      end
      if (n >= 2000) n_errors++;
      check(32'(reply_instr), 32'(ins));
      check(32'(reply_status), 32'(exp_st));
      check(reply_value, exp_val);
      @(posedge mclk);
      reply_ready <= 1'b1;
      @(posedge mclk);
      reply_ready <= 1'b0;
   endtask

   task automatic t_init();
      int n;
      repeat (3) @(negedge mclk);
      check(32'(rx_ready), 32'h0);
      n = 0;
      while (init_done !== 1'b1 && n < 5000) begin
         @(negedge mclk);
         n++;
      end
      if (n >= 5000) n_errors++;
      check(32'(ser_addr), 32'h1);
      @(posedge mclk);
      slow <= 1'b0;
      cmd(`GPCH_INS_GET, 8'h00, 8'h02, 32'h0, 1'b0, 8'h64, nv_init(2, 0));
      cmd(`GPCH_INS_GET, 8'(NPAR - 1), 8'h02, 32'h0, 1'b0, 8'h64,
          nv_init(2, 8'(NPAR - 1)));
      check(accum, nv_init(2, 8'(NPAR - 1)));
   endtask

   task automatic t_set_get();
      logic [7:0] bk [0:2];
      bk = '{8'h00, 8'h02, 8'h03};
      for (int i = 0; i < 3; i++) begin
         cmd(`GPCH_INS_SET, 8'h05, bk[i], 32'h11223344 ^ i, 1'b0, 8'h64, 0);
         cmd(`GPCH_INS_GET, 8'h05, bk[i], 32'h0, 1'b0, 8'h64,
             32'h11223344 ^ i);
         check(accum, 32'h11223344 ^ i);
      end
      // Banks keep separate storage for the same parameter number
      cmd(`GPCH_INS_GET, 8'h05, 8'h00, 32'h0, 1'b0, 8'h64, 32'h11223344);
      check(i_gpch_nv_model.mem[{2'd0, 8'h05}], 32'h11223344);
      check(i_gpch_nv_model.mem[{2'd2, 8'h05}], nv_init(2, 5));
      check(i_gpch_nv_model.mem[{2'd3, 8'h05}], nv_init(3, 5));
   endtask

   task automatic t_store_restore();
      slow <= 1'b1;
      cmd(`GPCH_INS_SET, 8'h07, 8'h02, 32'hcafe0001, 1'b0, 8'h64, 0);
      cmd(`GPCH_INS_STORE, 8'h07, 8'h02, 32'h0, 1'b0, 8'h64, 0);
      check(i_gpch_nv_model.mem[{2'd2, 8'h07}], 32'hcafe0001);
      cmd(`GPCH_INS_SET, 8'h07, 8'h02, 32'h0badf00d, 1'b0, 8'h64, 0);
      cmd(`GPCH_INS_RESTORE, 8'h07, 8'h02, 32'h0, 1'b0, 8'h64, 0);
      cmd(`GPCH_INS_GET, 8'h07, 8'h02, 32'h0, 1'b0, 8'h64, 32'hcafe0001);
      slow <= 1'b0;
   endtask

   task automatic t_refuse();
      cmd(`GPCH_INS_SET, 8'h09, 8'h02, 32'h12345678, 1'b1, 8'h01, 0);
      cmd(`GPCH_INS_GET, 8'h09, 8'h02, 32'h0, 1'b0, 8'h64, nv_init(2, 9));
      cmd(8'h05, 8'h00, 8'h00, 32'h0, 1'b0, 8'h02, 0);
      cmd(`GPCH_INS_SET, 8'(NPAR), 8'h02, 32'h1, 1'b0, 8'h03, 0);
      cmd(`GPCH_INS_SET, 8'h01, 8'h01, 32'h1, 1'b0, 8'h04, 0);
      cmd(`GPCH_INS_STORE, 8'h01, 8'h00, 32'h0, 1'b0, 8'h04, 0);
      cmd(`GPCH_INS_RESTORE, 8'h01, 8'h03, 32'h0, 1'b0, 8'h04, 0);
   endtask

   // A low clock enable must hold the handler in place mid-command
   task automatic t_freeze();
      int n;
      send_frame(`GPCH_INS_GET, 8'h05, 8'h02, 32'h0, 1'b0);
      ce <= 1'b0;
      repeat (4) @(negedge mclk);
      check(32'(reply_valid), 32'h0);
      check(32'(rx_ready), 32'h0);
      @(posedge mclk);
      ce <= 1'b1;
      n = 0;
      @(negedge mclk);
      while (reply_valid !== 1'b1 && n < 2000) begin
         @(negedge mclk);
         n++;
      end
      if (n >= 2000) n_errors++;
      check(reply_value, 32'h11223345);
      check(accum, 32'h11223345);
      @(posedge mclk);
      ce          <= 1'b0;
      reply_ready <= 1'b1;
      repeat (3) @(negedge mclk);
      check(32'(reply_valid), 32'h1);
      @(posedge mclk);
      ce <= 1'b1;
      @(posedge mclk);
      reply_ready <= 1'b0;
   endtask

   task automatic t_address();
      logic heard;
      heard = 1'b0;
      cmd(`GPCH_INS_SET, `GPCH_SERADDR_IDX, 8'h00, 32'h3, 1'b0, 8'h64, 0);
      check(32'(ser_addr), 32'h3);
      send_frame(`GPCH_INS_GET, 8'h05, 8'h00, 32'h0, 1'b0);
      repeat (30) begin
         @(negedge mclk);
         if (reply_valid === 1'b1) heard = 1'b1;
      end
      check(32'(heard), 32'h0);
      check(32'(rx_ready), 32'h1);
      @(posedge mclk);
      dev_addr = 8'h03;
      cmd(`GPCH_INS_GET, `GPCH_SERADDR_IDX, 8'h00, 32'h0, 1'b0, 8'h64, 3);
   endtask

   initial begin
      resetn      = 1'b0;
      rx_valid    = 1'b0;
      rx_byte     = 8'h00;
      reply_ready = 1'b0;
      slow        = 1'b1;
      ce          = 1'b1;
      dev_addr    = 8'h01;
      n_errors    = 0;
      num_checks  = 0;
      repeat (12) @(posedge mclk);
      resetn <= 1'b1;
      t_init();
      t_set_get();
      t_store_restore();
      t_refuse();
      t_freeze();
      t_address();
      stop_test();
   end

   // Whole run needs well under two thousand cycles; this is a generous ceiling
   initial begin
      repeat (20000) @(posedge mclk);
      n_errors++;
      stop_test();
   end
endmodule
